// ### sig_socket_model.sv
// behavioural part in the socket: outputs are the driven pins rotated left by one, xor a register state
// assumes drive and preload come from the tester on clk_i; fault_i is set only by the bench
`timescale 1ns/10ps
module sig_socket_model #(
    parameter int PINS = 28
) (
    input  wire logic            clk_i,
    input  wire logic [PINS-1:0] drive_i,
    input  wire logic            preload_i,
    input  wire logic            fault_i,
    output logic      [PINS-1:0] sample_o,
    output int                   preload_cnt_o
);
    // the registered part powers up in an arbitrary state; only a preload makes it known
    logic [PINS-1:0] state_ff = PINS'(28'h5a5a5a5);
    int              cnt_ff   = 0;

    always_ff @(posedge clk_i) begin
        if (preload_i) begin
            state_ff <= '0;
            cnt_ff   <= cnt_ff + 1;
        end
    end

    // a faulty part flips one output bit that every comparison sees; a preload takes hold while
    // its strobe stands, so the compare of that same vector already sees the known state
    assign sample_o      = {drive_i[PINS-2:0], drive_i[PINS-1]} ^ (preload_i ? {PINS{1'b0}} : state_ff)
                           ^ {{(PINS-2){1'b0}}, fault_i, 1'b0};
    assign preload_cnt_o = cnt_ff;
endmodule

// ### sig_tester.sv
// structured vector test and pseudo-random signature test sequencer
// assumes socket pins and register port are synchronous to clk_i
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`include "sig_tester_params.svh"

// Operation
// - learn reference sum, later pass only on match
// - reference sum also writable by software
// - load runs structured test before learning
// - structured failure in load aborts, code 75
// - cycle count up to 99; zero disables
// - operator start vector, reset all zeros
// - start vector width follows pin count
// - loaded structured vectors run before signature unless skipped
// - pseudo-random drive, outputs folded into sum; taps are bits 27 and 24, so below 28 pins the drive fills with ones
// - preload strobe on flagged vectors when supported
// - vectors load through the same register path
// - verify option 1 skips structured test
module sig_tester #(
    parameter int PINS      = 28,
    parameter int VEC_DEPTH = 16,
    parameter int STEPS     = `STEPS_DEF
) (
    input  wire logic            clk_i,
    input  wire logic            rstn_i,
    input  wire logic            ce_i,
    input  wire logic [7:0]      addr_i,
    input  wire logic [31:0]     wdata_i,
    input  wire logic            wr_i,
    input  wire logic            rd_i,
    output logic      [31:0]     rdata_o,
    input  wire logic [PINS-1:0] dut_sample_i,
    output logic      [PINS-1:0] dut_drive_o,
    output logic                 dut_preload_o,
    output logic                 busy_o,
    output logic                 pass_o,
    output logic                 fail_o
);
    localparam int AW = (VEC_DEPTH > 1) ? $clog2(VEC_DEPTH) : 1;
    localparam int SW = (STEPS > 1) ? $clog2(STEPS) : 1;

    if (PINS < 20 || PINS > 28 || VEC_DEPTH < 1 || VEC_DEPTH > 255 || STEPS < 1) begin : g_bad_param
        $error("sig_tester parameters out of range");
    end

    sig_tester_pkg::state_t state_ff;
    sig_tester_pkg::ctrl_t  ctrl_ff;
    sig_tester_pkg::flags_t flags_ff;
    logic            go_ff;
    logic [6:0]      cycles_ff;
    logic [PINS-1:0] start_ff;
    logic [4:0]      pins_ff;
    logic [PINS-1:0] outmask_ff;
    logic [31:0]     ref_ff;
    logic [31:0]     sum_ff;
    logic [PINS-1:0] lfsr_ff;
    logic [7:0]      err_ff;
    logic [7:0]      vcnt_ff;
    logic [AW-1:0]   idx_ff;
    logic            phase_ff;
    logic [6:0]      cyc_ff;
    logic [SW-1:0]   step_ff;
    logic [PINS-1:0] vdrv_mem [VEC_DEPTH];
    logic [PINS-1:0] vexp_mem [VEC_DEPTH];
    logic            vpre_mem [VEC_DEPTH];
    logic [PINS-1:0] pend_drv_ff;
    logic            pend_pre_ff;

    // pins above the device's pin count are never driven nor counted
    function automatic logic [PINS-1:0] width_mask(input logic [4:0] pc);
        logic [63:0] m;
        m = (64'h1 << pc) - 64'h1;
        return m[PINS-1:0];
    endfunction

    function automatic logic hit(input logic [7:0] ofs);
        return addr_i == ofs;
    endfunction

    logic [PINS-1:0] pmask;
    logic            mism;
    logic            run_svt;
    logic            learn;
    logic [PINS-1:0] nxt_lfsr;
    assign pmask    = width_mask(pins_ff);
    assign mism     = |((dut_sample_i ^ vexp_mem[idx_ff]) & outmask_ff & pmask);
    assign run_svt  = (vcnt_ff != 8'h00) && (ctrl_ff.verify_opt != `VOPT_SKIP);
    assign learn    = ctrl_ff.load_op && ctrl_ff.from_master;
    // xnor feedback keeps the all-zero default start from locking up
    assign nxt_lfsr = {lfsr_ff[PINS-2:0], ~(lfsr_ff[PINS-1] ^ lfsr_ff[PINS-4])};

    // control, count, start vector and pin set-up
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ctrl_ff    <= '0;
            go_ff      <= 1'b0;
            cycles_ff  <= `CYCLES_RST;
            start_ff   <= PINS'(`START_RST);
            pins_ff    <= `PINS_RST;
            outmask_ff <= '0;
        end else if (ce_i) begin
            go_ff <= wr_i && hit(`OFS_CTRL) && wdata_i[`CTRL_GO] && state_ff == sig_tester_pkg::ST_IDLE;
            if (wr_i && hit(`OFS_CTRL)) begin
                ctrl_ff.load_op     <= wdata_i[`CTRL_LOAD];
                ctrl_ff.from_master <= wdata_i[`CTRL_MASTER];
                ctrl_ff.verify_opt  <= wdata_i[`CTRL_VOPT_LO+:2];
                ctrl_ff.preload_ok  <= wdata_i[`CTRL_PRELOAD];
            end
            // larger counts are refused and the old value kept
            if (wr_i && hit(`OFS_CYCLES) && wdata_i[6:0] <= `CYCLES_MAX && wdata_i[31:7] == '0) begin
                cycles_ff <= wdata_i[6:0];
            end
            if (wr_i && hit(`OFS_START)) begin
                start_ff <= wdata_i[PINS-1:0];
            end
            if (wr_i && hit(`OFS_PINS) && (wdata_i[4:0] == 5'h14 || wdata_i[4:0] == 5'h18
                                           || wdata_i[4:0] == 5'h1c) && wdata_i[4:0] <= 5'(PINS)) begin
                pins_ff <= wdata_i[4:0];
            end
            if (wr_i && hit(`OFS_OUTMASK)) begin
                outmask_ff <= wdata_i[PINS-1:0];
            end
        end
    end

    // structured vectors: drive word is held, expect word commits the entry
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            vcnt_ff     <= 8'h00;
            pend_drv_ff <= '0;
            pend_pre_ff <= 1'b0;
        end else if (ce_i && state_ff == sig_tester_pkg::ST_IDLE) begin
            if (wr_i && hit(`OFS_CTRL) && wdata_i[`CTRL_VCLR]) begin
                vcnt_ff <= 8'h00;
            end else if (wr_i && hit(`OFS_VDRIVE)) begin
                pend_drv_ff <= wdata_i[PINS-1:0];
                pend_pre_ff <= wdata_i[`VDRV_PRELOAD];
            end else if (wr_i && hit(`OFS_VEXPECT) && vcnt_ff < 8'(VEC_DEPTH)) begin
                vcnt_ff <= vcnt_ff + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (ce_i && state_ff == sig_tester_pkg::ST_IDLE && wr_i && hit(`OFS_VEXPECT)
            && vcnt_ff < 8'(VEC_DEPTH)) begin
            vdrv_mem[vcnt_ff[AW-1:0]] <= pend_drv_ff;
            vexp_mem[vcnt_ff[AW-1:0]] <= wdata_i[PINS-1:0];
            vpre_mem[vcnt_ff[AW-1:0]] <= pend_pre_ff;
        end
    end

    // reference sum: learned from the master or entered by software
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ref_ff             <= 32'h00000000;
        end else if (ce_i) begin
            if (state_ff == sig_tester_pkg::ST_CMP && learn) begin
                ref_ff             <= sum_ff;
            end else if (wr_i && hit(`OFS_REFSUM) && state_ff == sig_tester_pkg::ST_IDLE) begin
                ref_ff             <= wdata_i;
            end
        end
    end

    // test sequence
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            state_ff       <= sig_tester_pkg::ST_IDLE;
            flags_ff.busy  <= 1'b0;
            flags_ff.pass  <= 1'b0;
            flags_ff.fail  <= 1'b0;
            flags_ff.ref_valid <= 1'b0;
            err_ff         <= 8'h00;
            idx_ff         <= '0;
            phase_ff       <= 1'b0;
            cyc_ff         <= 7'h00;
            step_ff        <= '0;
            lfsr_ff        <= '0;
            sum_ff         <= 32'h00000000;
            dut_drive_o    <= '0;
            dut_preload_o  <= 1'b0;
        end else if (ce_i) begin
            dut_preload_o <= 1'b0;
            case (state_ff)
                sig_tester_pkg::ST_IDLE: begin
                    if (wr_i && hit(`OFS_REFSUM)) begin
                        flags_ff.ref_valid <= 1'b1;
                    end
                    if (go_ff) begin
                        flags_ff.pass <= 1'b0;
                        flags_ff.fail <= 1'b0;
                        flags_ff.busy <= 1'b1;
                        err_ff        <= 8'h00;
                        idx_ff        <= '0;
                        phase_ff      <= 1'b0;
                        cyc_ff        <= 7'h00;
                        step_ff       <= '0;
                        sum_ff        <= 32'h00000000;
                        lfsr_ff       <= start_ff & pmask;
                        if (run_svt) begin
                            state_ff <= sig_tester_pkg::ST_SVT;
                        end else if (cycles_ff != 7'h00) begin
                            state_ff <= sig_tester_pkg::ST_SIG;
                        end else begin
                            flags_ff.busy <= 1'b0;
                            flags_ff.pass <= 1'b1;
                        end
                    end
                end
                sig_tester_pkg::ST_SVT: begin
                    if (!phase_ff) begin
                        dut_drive_o   <= vdrv_mem[idx_ff] & pmask;
                        dut_preload_o <= vpre_mem[idx_ff] & ctrl_ff.preload_ok;
                        phase_ff      <= 1'b1;
                    end else if (mism) begin
                        state_ff      <= sig_tester_pkg::ST_IDLE;
                        flags_ff.busy <= 1'b0;
                        flags_ff.fail <= 1'b1;
                        if (ctrl_ff.load_op) begin
                            err_ff <= `ERR_SVT_LOAD;
                        end
                    end else if ({{(8-AW){1'b0}}, idx_ff} == vcnt_ff - 8'h01) begin
                        phase_ff <= 1'b0;
                        if (cycles_ff != 7'h00) begin
                            state_ff <= sig_tester_pkg::ST_SIG;
                        end else begin
                            state_ff      <= sig_tester_pkg::ST_IDLE;
                            flags_ff.busy <= 1'b0;
                            flags_ff.pass <= 1'b1;
                        end
                    end else begin
                        idx_ff   <= idx_ff + AW'(1);
                        phase_ff <= 1'b0;
                    end
                end
                sig_tester_pkg::ST_SIG: begin
                    // the sample seen here answers the vector driven one cycle before; on the first
                    // clock that is a leftover drive, kept out so the sum depends only on the start
                    dut_drive_o <= lfsr_ff & pmask;
                    lfsr_ff     <= nxt_lfsr & pmask;
                    if (cyc_ff != 7'h00 || step_ff != '0) begin
                        sum_ff <= {sum_ff[30:0], sum_ff[31]} ^ 32'(dut_sample_i & pmask);
                    end
                    if (step_ff == SW'(STEPS - 1)) begin
                        step_ff <= '0;
                        if (cyc_ff == cycles_ff - 7'h01) begin
                            state_ff <= sig_tester_pkg::ST_CMP;
                        end else begin
                            cyc_ff <= cyc_ff + 7'h01;
                        end
                    end else begin
                        step_ff <= step_ff + SW'(1);
                    end
                end
                sig_tester_pkg::ST_CMP: begin
                    state_ff      <= sig_tester_pkg::ST_IDLE;
                    flags_ff.busy <= 1'b0;
                    if (learn) begin
                        flags_ff.pass      <= 1'b1;
                        flags_ff.ref_valid <= 1'b1;
                    end else begin
                        flags_ff.pass <= flags_ff.ref_valid && sum_ff == ref_ff;
                        flags_ff.fail <= !(flags_ff.ref_valid && sum_ff == ref_ff);
                    end
                end
                default: begin
                    state_ff <= sig_tester_pkg::ST_IDLE;
                end
            endcase
        end
    end

    assign busy_o = flags_ff.busy;
    assign pass_o = flags_ff.pass;
    assign fail_o = flags_ff.fail;

    // read data live only in the cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rdata_o <= 32'h00000000;
        end else if (ce_i) begin
            rdata_o <= 32'h00000000;
            if (rd_i) begin
                case (addr_i)
                    `OFS_CTRL:    rdata_o <= {26'h0, ctrl_ff.preload_ok, ctrl_ff.verify_opt,
                                              ctrl_ff.from_master, ctrl_ff.load_op, 1'b0};
                    `OFS_CYCLES:  rdata_o <= {25'h0, cycles_ff};
                    `OFS_START:   rdata_o <= 32'(start_ff);
                    `OFS_REFSUM:  rdata_o <= ref_ff;
                    `OFS_SUM:     rdata_o <= sum_ff;
                    `OFS_STATUS:  rdata_o <= {vcnt_ff, err_ff, 10'h0, state_ff, flags_ff};
                    `OFS_PINS:    rdata_o <= {27'h0, pins_ff};
                    `OFS_OUTMASK: rdata_o <= 32'(outmask_ff);
                    default:      rdata_o <= 32'h00000000;
                endcase
            end
        end
    end

    AST_CYCLES_MAX: assert property (@(posedge clk_i) disable iff (!rstn_i) cycles_ff <= `CYCLES_MAX)
        else $error("cycle count above limit");
    AST_LOAD_ABORT: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && state_ff == sig_tester_pkg::ST_SVT && phase_ff && mism && ctrl_ff.load_op
        |=> err_ff == `ERR_SVT_LOAD && fail_o && state_ff == sig_tester_pkg::ST_IDLE)
        else $error("structured failure in load did not abort with code 75");
    AST_SUM_FROZEN: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && state_ff == sig_tester_pkg::ST_CMP |=> $stable(sum_ff) && state_ff == sig_tester_pkg::ST_IDLE)
        else $error("sum moved during compare");
    AST_PASS_MATCH: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && state_ff == sig_tester_pkg::ST_CMP && !learn && sum_ff != ref_ff |=> fail_o && !pass_o)
        else $error("mismatching sum not failed");
    AST_SVT_FIRST: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && state_ff == sig_tester_pkg::ST_IDLE && go_ff && run_svt |=> state_ff == sig_tester_pkg::ST_SVT)
        else $error("signature test began before structured test");
    AST_VOPT_SKIP: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && state_ff == sig_tester_pkg::ST_IDLE && go_ff && ctrl_ff.verify_opt == `VOPT_SKIP
        |=> state_ff != sig_tester_pkg::ST_SVT)
        else $error("structured test not skipped");
    AST_START_VEC: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && state_ff == sig_tester_pkg::ST_IDLE && go_ff |=> lfsr_ff == (start_ff & pmask))
        else $error("stimulus not seeded from start vector");
    AST_PIN_WIDTH: assert property (@(posedge clk_i) disable iff (!rstn_i)
        busy_o |-> (dut_drive_o & ~pmask) == '0)
        else $error("pin beyond pin count driven");
    AST_PRELOAD: assert property (@(posedge clk_i) disable iff (!rstn_i)
        dut_preload_o |-> ctrl_ff.preload_ok && $past(state_ff) == sig_tester_pkg::ST_SVT)
        else $error("preload on unsupported part");
    AST_SIG_DRIVE: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && state_ff == sig_tester_pkg::ST_SIG |=> dut_drive_o == ($past(lfsr_ff) & pmask))
        else $error("stimulus not applied");
endmodule

// ### sig_tester_params.svh
// register offsets, field positions, reset values and counts of the device tester
// assumes a 32-bit word register port with byte addresses
`ifndef SIG_TESTER_PARAMS_SVH
`define SIG_TESTER_PARAMS_SVH
`define OFS_CTRL     8'h00
`define OFS_CYCLES   8'h04
`define OFS_START    8'h08
`define OFS_REFSUM   8'h0c
`define OFS_SUM      8'h10
`define OFS_STATUS   8'h14
`define OFS_VDRIVE   8'h18
`define OFS_VEXPECT  8'h1c
`define OFS_PINS     8'h20
`define OFS_OUTMASK  8'h24
`define CTRL_GO      0
`define CTRL_LOAD    1
`define CTRL_MASTER  2
`define CTRL_VOPT_LO 3
`define CTRL_PRELOAD 5
`define CTRL_VCLR    6
`define VDRV_PRELOAD 31
`define CYCLES_MAX   7'h63
`define CYCLES_RST   7'h00
`define START_RST    28'h0000000
`define PINS_RST     5'h14
`define VOPT_SKIP    2'h1
`define ERR_SVT_LOAD 8'h4b
`define STEPS_DEF    256
`endif

// ### sig_tester_pkg.sv
// types shared by the device tester
// assumes sig_tester_params.svh sits beside it
package sig_tester_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SVT  = 2'b01,
        ST_SIG  = 2'b10,
        ST_CMP  = 2'b11
    } state_t;
    typedef struct packed {
        logic [1:0] verify_opt;
        logic       preload_ok;
        logic       from_master;
        logic       load_op;
    } ctrl_t;
    typedef struct packed {
        logic       ref_valid;
        logic       fail;
        logic       pass;
        logic       busy;
    } flags_t;
endpackage

// ### test_signature_device_tester.sv
// self-checking bench of the device tester with a socket part model
// assumes sig_tester, sig_socket_model and sig_tester_params.svh are compiled beside it
`timescale 1ns/10ps
`include "sig_tester_params.svh"
module test_signature_device_tester;
    logic        clk_i     = 1'b0;
    logic        rstn_i    = 1'b0;
    logic [7:0]  addr_i    = 8'h00;
    logic [31:0] wdata_i   = 32'h0;
    logic        wr_i      = 1'b0;
    logic        rd_i      = 1'b0;
    logic        fault     = 1'b0;
    logic        ce        = 1'b1;
    logic [31:0] st;
    logic [31:0] rdata_o;
    logic [27:0] dut_sample_i;
    logic [27:0] dut_drive_o;
    logic        dut_preload_o;
    logic        busy_o;
    logic        pass_o;
    logic        fail_o;
    int          preload_cnt;
    int          pl0;
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          seed      = 87364;
    logic [31:0] rd_val;
    logic [31:0] sum_a;
    logic [31:0] drv;

    always #12.5 clk_i = ~clk_i;

    sig_tester #(.PINS(28), .VEC_DEPTH(16), .STEPS(4)) dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .dut_sample_i(dut_sample_i),
        .dut_drive_o(dut_drive_o), .dut_preload_o(dut_preload_o), .busy_o(busy_o),
        .pass_o(pass_o), .fail_o(fail_o));

    sig_socket_model #(.PINS(28)) part (
        .clk_i(clk_i), .drive_i(dut_drive_o), .preload_i(dut_preload_o), .fault_i(fault),
        .sample_o(dut_sample_i), .preload_cnt_o(preload_cnt));

    function automatic logic [31:0] rot(input logic [31:0] d);
        return {4'h0, d[26:0], d[27]};
    endfunction

    // test-sum of a good preloaded 20-pin part: n clocks, the first clock's sample left out
    function automatic logic [31:0] exp_sum(input logic [31:0] sv, input int n);
        logic [31:0] s;
        logic [31:0] l;
        s = 32'h0;
        l = sv & 32'hfffff;
        for (int k = 0; k < n - 1; k++) begin
            s = {s[30:0], s[31]} ^ (rot(l) & 32'hfffff);
            l = {l[30:0], ~(l[27] ^ l[24])} & 32'hfffff;
        end
        return s;
    endfunction

    task automatic summarize();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so they are taken just after that edge
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] v;
        reg_rd(a, v);
        chk(v, exp, what);
    endtask

    task automatic run(input logic [31:0] ctrl, input logic exp_pass, input string what);
        int n;
        reg_wr(`OFS_CTRL, ctrl | 32'h1);
        repeat (3) @(posedge clk_i);
        n = 0;
        while (busy_o === 1'b1 && n < 5000) begin
            @(posedge clk_i);
            n++;
        end
        #1;
        chk({30'h0, pass_o, fail_o}, {30'h0, exp_pass, ~exp_pass}, what);
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        summarize();
    end

    initial begin
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        rd_chk(`OFS_CYCLES, 32'h0, "cycles reset");
        rd_chk(`OFS_START, 32'h0, "start reset");
        rd_chk(`OFS_PINS, 32'h14, "pins reset");
        rd_chk(`OFS_STATUS, 32'h0, "status reset");
        rd_chk(8'h3c, 32'h0, "unmapped read");
        run(32'h0, 1'b1, "test disabled");
        reg_wr(`OFS_CYCLES, 32'h64);
        rd_chk(`OFS_CYCLES, 32'h0, "cycles over max");
        reg_wr(`OFS_CYCLES, 32'h63);
        rd_chk(`OFS_CYCLES, 32'h63, "cycles max");
        reg_wr(`OFS_CYCLES, 32'h2);
        // a write while the clock enable is low must leave the count alone
        @(posedge clk_i);
        ce <= 1'b0;
        reg_wr(`OFS_CYCLES, 32'h5);
        ce <= 1'b1;
        rd_chk(`OFS_CYCLES, 32'h2, "frozen while disabled");
        reg_wr(`OFS_PINS, 32'h16);
        rd_chk(`OFS_PINS, 32'h14, "pins refused");
        reg_wr(`OFS_PINS, 32'h18);
        rd_chk(`OFS_PINS, 32'h18, "pins 24");
        reg_wr(`OFS_PINS, 32'h14);
        // an all-zero start is avoided by forcing bit 0 of the start vector to one
        st = $random(seed) & 32'hfffff | 32'h1;
        reg_wr(`OFS_START, st);
        rd_chk(`OFS_START, st, "start vector");
        reg_wr(`OFS_CTRL, 32'h40);
        reg_wr(`OFS_OUTMASK, 32'hffffe);
        // two setup vectors go through the structured test, the first with preload
        for (int i = 0; i < 2; i++) begin
            drv = $random(seed) & 32'hfffff;
            reg_wr(`OFS_VDRIVE, drv | (i == 0 ? 32'h80000000 : 32'h0));
            reg_wr(`OFS_VEXPECT, rot(drv));
        end
        rd_chk(`OFS_STATUS, 32'h02000002, "vector count");
        sum_a = exp_sum(st, 8);
        pl0 = preload_cnt;
        run(32'h26, 1'b1, "learn from master");
        chk(32'(preload_cnt - pl0), 32'h1, "preload strobe");
        rd_chk(`OFS_STATUS, 32'h0200000a, "ref learned");
        rd_chk(`OFS_REFSUM, sum_a, "learned sum");
        run(32'h20, 1'b1, "good part");
        rd_chk(`OFS_SUM, sum_a, "sum held");
        fault <= 1'b1;
        run(32'h28, 1'b0, "faulty part signature");
        run(32'h26, 1'b0, "structured fail in load");
        reg_rd(`OFS_STATUS, rd_val);
        chk({24'h0, rd_val[23:16]}, 32'h4b, "load error code");
        fault <= 1'b0;
        reg_wr(`OFS_VDRIVE, 32'h0);
        reg_wr(`OFS_VEXPECT, 32'hffffe);
        run(32'h28, 1'b1, "structured skipped");
        run(32'h20, 1'b0, "bad vector runs first");
        reg_wr(`OFS_REFSUM, sum_a ^ 32'h1);
        rd_chk(`OFS_REFSUM, sum_a ^ 32'h1, "ref entry");
        run(32'h28, 1'b0, "entered ref differs");
        reg_wr(`OFS_REFSUM, sum_a);
        run(32'h28, 1'b1, "entered ref matches");
        summarize();
    end
endmodule
